// ### bsc_cfg.svh
// Purpose: Constants for the branch and skip control decoder.
// Assumes: 16-bit instruction words, 8-bit status register.
// Notes: Opcodes are given as a mask and a match value, except sleep, watchdog restart and break, which match as a whole word.
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// ********************************************************
// Opcode masks and match values
// ********************************************************
`define BSC_SKIP_REG_MASK 16'hFE08
`define BSC_SKIP_REG_CLR_VAL 16'hFC00
`define BSC_SKIP_REG_SET_VAL 16'hFE00
`define BSC_SKIP_IO_MASK 16'hFF00
`define BSC_SKIP_IO_CLR_VAL 16'h9900
`define BSC_SKIP_IO_SET_VAL 16'h9B00
`define BSC_BRANCH_MASK 16'hFC00
`define BSC_BRANCH_SET_VAL 16'hF000
`define BSC_BRANCH_CLR_VAL 16'hF400
`define BSC_STACK_MASK 16'hFE0F
`define BSC_PUSH_VAL 16'h920F
`define BSC_POP_VAL 16'h900F
`define BSC_SLEEP_VAL 16'h9588
`define BSC_WATCHDOG_RESTART_VAL 16'h95A8
`define BSC_BREAK_VAL 16'h9598

// ********************************************************
// Two-word instruction patterns
// ********************************************************
`define BSC_LOAD_DIRECT_MASK 16'hFE0F
`define BSC_LOAD_DIRECT_VAL 16'h9000
`define BSC_STORE_DIRECT_VAL 16'h9200
`define BSC_FAR_FLOW_MASK 16'hFE0E
`define BSC_FAR_JUMP_VAL 16'h940C
`define BSC_FAR_CALL_VAL 16'h940E

// ********************************************************
// Field positions
// ********************************************************
`define BSC_REG_FIELD_HI 8
`define BSC_REG_FIELD_LO 4
`define BSC_IO_FIELD_HI 7
`define BSC_IO_FIELD_LO 3
`define BSC_BIT_FIELD_HI 2
`define BSC_BIT_FIELD_LO 0
`define BSC_OFS_FIELD_HI 9
`define BSC_OFS_FIELD_LO 3

// ********************************************************
// Status register flag positions
// ********************************************************
`define BSC_FLAG_CARRY 3'h0
`define BSC_FLAG_ZERO 3'h1
`define BSC_FLAG_NEG 3'h2
`define BSC_FLAG_OVF 3'h3
`define BSC_FLAG_SIGN 3'h4
`define BSC_FLAG_HALF 3'h5
`define BSC_FLAG_TRANSFER 3'h6

// ********************************************************
// Extra skip cycles beyond the first and program counter steps
// ********************************************************
`define BSC_EXTRA_SKIP_ONE 2'h1
`define BSC_EXTRA_SKIP_TWO 2'h2
`define BSC_STEP_ONE 2'h1
`define BSC_STEP_SKIP_ONE 2'h2
`define BSC_STEP_SKIP_TWO 2'h3

`endif

// ### bsc_pkg.sv
// Purpose: Types shared by the branch and skip control decoder.
// Assumes: Constants come from bsc_cfg.svh.
// Notes: No numbers live here.
package bsc_pkg;

  // ********************************************************
  // Sequencer states and decoded operations
  // ********************************************************
  typedef enum logic [2:0] {
    ST_READY,
    ST_SKIP,
    ST_BRANCH,
    ST_PUSH,
    ST_POP
  } bsc_state_t;

  typedef enum logic [3:0] {
    OP_OTHER,
    OP_SKIP_REG_CLR,
    OP_SKIP_REG_SET,
    OP_SKIP_IO_CLR,
    OP_SKIP_IO_SET,
    OP_BRANCH_SET,
    OP_BRANCH_CLR,
    OP_PUSH,
    OP_POP,
    OP_SLEEP,
    OP_WATCHDOG_RESTART,
    OP_BREAK
  } bsc_op_t;

endpackage : bsc_pkg

// ### bsc_word_len.sv
// Purpose: Tells whether an instruction word opens a two-word instruction.
// Assumes: The word is the one that follows the current instruction.
// Notes: Purely combinational.
`timescale 1ns/1ns
`include "bsc_cfg.svh"

module bsc_word_len (
  // Instruction word
  input wire logic [15:0] word_in,
  // Result
  output logic two_word_out
);

  // ********************************************************
  // Pattern match
  // ********************************************************
  always_comb begin
    two_word_out = ((word_in & `BSC_LOAD_DIRECT_MASK) == `BSC_LOAD_DIRECT_VAL) ||
                   ((word_in & `BSC_LOAD_DIRECT_MASK) == `BSC_STORE_DIRECT_VAL) ||
                   ((word_in & `BSC_FAR_FLOW_MASK) == `BSC_FAR_JUMP_VAL) ||
                   ((word_in & `BSC_FAR_FLOW_MASK) == `BSC_FAR_CALL_VAL);
  end

endmodule : bsc_word_len

// ### bsc_decoder.sv
// Purpose: Decodes and sequences skip, branch, stack and core control instructions.
// Assumes: Register, I/O and stack read data answer in the same cycle.
// Notes: The program counter lives here; status flags are only read.
`timescale 1ns/1ns
`include "bsc_cfg.svh"

module bsc_decoder #(
  parameter int PC_W = 14,
  parameter logic [PC_W-1:0] RESET_PC = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Instruction fetch
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] next_word_in,
  output logic ready_out,
  output logic [PC_W-1:0] pc_out,
  output logic taken_out,
  // Operand lookup
  output logic [4:0] reg_addr_out,
  input wire logic [7:0] reg_data_in,
  output logic [4:0] io_addr_out,
  input wire logic [7:0] io_data_in,
  input wire logic [7:0] status_register_in,
  // Stack port
  output logic stack_wr_out,
  output logic [7:0] stack_wdata_out,
  output logic stack_rd_out,
  input wire logic [7:0] stack_rdata_in,
  // Register write back
  output logic rf_we_out,
  output logic [4:0] rf_waddr_out,
  output logic [7:0] rf_wdata_out,
  // Core control
  output logic sleep_out,
  output logic watchdog_restart_out,
  output logic break_out
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    bsc_pkg::bsc_state_t fsm;
    logic [1:0] wait_cnt;
    logic [PC_W-1:0] pc;
    logic taken;
    logic stack_wr;
    logic [7:0] stack_wdata;
    logic stack_rd;
    logic [4:0] pop_dest;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [7:0] rf_wdata;
    logic sleep;
    logic watchdog_restart;
    logic brk;
  } bsc_regs_t;

  bsc_regs_t state_reg;
  bsc_regs_t state_next;

  bsc_pkg::bsc_op_t op;
  logic accept;
  logic next_two_word;
  logic [2:0] bit_sel;
  logic [2:0] flag_sel;
  logic flag_val;
  logic reg_bit;
  logic io_bit;
  logic skip;
  logic branch;
  logic [PC_W-1:0] offset;
  logic [PC_W-1:0] pc_plus;

  // ********************************************************
  // Word length of the following instruction
  // ********************************************************
  bsc_word_len u_word_len (
    .word_in(next_word_in),
    .two_word_out(next_two_word)
  );

  // ********************************************************
  // Opcode decode
  // ********************************************************
  always_comb begin
    if ((instr_in & `BSC_SKIP_REG_MASK) == `BSC_SKIP_REG_CLR_VAL) begin
      op = bsc_pkg::OP_SKIP_REG_CLR;
    end else if ((instr_in & `BSC_SKIP_REG_MASK) == `BSC_SKIP_REG_SET_VAL) begin
      op = bsc_pkg::OP_SKIP_REG_SET;
    end else if ((instr_in & `BSC_SKIP_IO_MASK) == `BSC_SKIP_IO_CLR_VAL) begin
      op = bsc_pkg::OP_SKIP_IO_CLR;
    end else if ((instr_in & `BSC_SKIP_IO_MASK) == `BSC_SKIP_IO_SET_VAL) begin
      op = bsc_pkg::OP_SKIP_IO_SET;
    end else if ((instr_in & `BSC_BRANCH_MASK) == `BSC_BRANCH_SET_VAL) begin
      op = bsc_pkg::OP_BRANCH_SET;
    end else if ((instr_in & `BSC_BRANCH_MASK) == `BSC_BRANCH_CLR_VAL) begin
      op = bsc_pkg::OP_BRANCH_CLR;
    end else if ((instr_in & `BSC_STACK_MASK) == `BSC_PUSH_VAL) begin
      op = bsc_pkg::OP_PUSH;
    end else if ((instr_in & `BSC_STACK_MASK) == `BSC_POP_VAL) begin
      op = bsc_pkg::OP_POP;
    end else if (instr_in == `BSC_SLEEP_VAL) begin
      op = bsc_pkg::OP_SLEEP;
    end else if (instr_in == `BSC_WATCHDOG_RESTART_VAL) begin
      op = bsc_pkg::OP_WATCHDOG_RESTART;
    end else if (instr_in == `BSC_BREAK_VAL) begin
      op = bsc_pkg::OP_BREAK;
    end else begin
      op = bsc_pkg::OP_OTHER;
    end
  end

  // ********************************************************
  // Operand lookup and condition tests
  // ********************************************************
  // Register and I/O addresses go straight out so that the operand is back within the same cycle.
  assign reg_addr_out = instr_in[`BSC_REG_FIELD_HI:`BSC_REG_FIELD_LO];
  assign io_addr_out = instr_in[`BSC_IO_FIELD_HI:`BSC_IO_FIELD_LO];
  assign bit_sel = instr_in[`BSC_BIT_FIELD_HI:`BSC_BIT_FIELD_LO];
  assign flag_sel = instr_in[`BSC_BIT_FIELD_HI:`BSC_BIT_FIELD_LO];
  assign reg_bit = reg_data_in[bit_sel];
  assign io_bit = io_data_in[bit_sel];

  always_comb begin
    // The sign test is rebuilt from negative and overflow so it never trusts a stale sign flag.
    if (flag_sel == `BSC_FLAG_SIGN) begin
      flag_val = status_register_in[`BSC_FLAG_NEG] ^ status_register_in[`BSC_FLAG_OVF];
    end else begin
      flag_val = status_register_in[flag_sel];
    end
  end

  always_comb begin
    skip = 1'b0;
    branch = 1'b0;
    unique case (op)
      bsc_pkg::OP_SKIP_REG_CLR: begin
        skip = !reg_bit;
      end
      bsc_pkg::OP_SKIP_REG_SET: begin
        skip = reg_bit;
      end
      bsc_pkg::OP_SKIP_IO_CLR: begin
        skip = !io_bit;
      end
      bsc_pkg::OP_SKIP_IO_SET: begin
        skip = io_bit;
      end
      bsc_pkg::OP_BRANCH_SET: begin
        branch = flag_val;
      end
      bsc_pkg::OP_BRANCH_CLR: begin
        branch = !flag_val;
      end
      default: begin
        skip = 1'b0;
        branch = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // Program counter arithmetic
  // ********************************************************
  // The target wraps silently at the top of program space, so code near the edge must not rely on it.
  assign offset = PC_W'($signed(instr_in[`BSC_OFS_FIELD_HI:`BSC_OFS_FIELD_LO]));

  always_comb begin
    if (branch) begin
      pc_plus = state_reg.pc + offset + PC_W'(`BSC_STEP_ONE);
    end else if (skip && next_two_word) begin
      pc_plus = state_reg.pc + PC_W'(`BSC_STEP_SKIP_TWO);
    end else if (skip) begin
      pc_plus = state_reg.pc + PC_W'(`BSC_STEP_SKIP_ONE);
    end else begin
      pc_plus = state_reg.pc + PC_W'(`BSC_STEP_ONE);
    end
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  assign ready_out = (state_reg.fsm == bsc_pkg::ST_READY);
  assign accept = instr_valid_in && ready_out;

  always_comb begin
    state_next = state_reg;
    state_next.stack_wr = 1'b0;
    state_next.stack_rd = 1'b0;
    state_next.rf_we = 1'b0;
    state_next.sleep = 1'b0;
    state_next.watchdog_restart = 1'b0;
    state_next.brk = 1'b0;
    unique case (state_reg.fsm)
      bsc_pkg::ST_READY: begin
        if (accept) begin
          state_next.pc = pc_plus;
          state_next.taken = skip || branch;
          if (skip) begin
            // One wait cycle for each word passed over.
            state_next.fsm = bsc_pkg::ST_SKIP;
            state_next.wait_cnt = next_two_word ? `BSC_EXTRA_SKIP_TWO : `BSC_EXTRA_SKIP_ONE;
          end else if (branch) begin
            state_next.fsm = bsc_pkg::ST_BRANCH;
          end else if (op == bsc_pkg::OP_PUSH) begin
            state_next.fsm = bsc_pkg::ST_PUSH;
            state_next.stack_wr = 1'b1;
            state_next.stack_wdata = reg_data_in;
          end else if (op == bsc_pkg::OP_POP) begin
            state_next.fsm = bsc_pkg::ST_POP;
            state_next.stack_rd = 1'b1;
            state_next.pop_dest = instr_in[`BSC_REG_FIELD_HI:`BSC_REG_FIELD_LO];
          end else begin
            state_next.sleep = (op == bsc_pkg::OP_SLEEP);
            state_next.watchdog_restart = (op == bsc_pkg::OP_WATCHDOG_RESTART);
            // Outside a debug session nothing else reacts to this pulse.
            state_next.brk = (op == bsc_pkg::OP_BREAK);
          end
        end
      end
      bsc_pkg::ST_SKIP: begin
        state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
        if (state_reg.wait_cnt == `BSC_EXTRA_SKIP_ONE) begin
          state_next.fsm = bsc_pkg::ST_READY;
        end
      end
      bsc_pkg::ST_BRANCH: begin
        state_next.fsm = bsc_pkg::ST_READY;
      end
      bsc_pkg::ST_PUSH: begin
        state_next.fsm = bsc_pkg::ST_READY;
      end
      bsc_pkg::ST_POP: begin
        // Write back lands one cycle later, overlapping the next instruction.
        state_next.rf_we = 1'b1;
        state_next.rf_waddr = state_reg.pop_dest;
        state_next.rf_wdata = stack_rdata_in;
        state_next.fsm = bsc_pkg::ST_READY;
      end
      default: begin
        // An unused state code falls back to ready rather than locking the core.
        state_next.fsm = bsc_pkg::ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '{fsm: bsc_pkg::ST_READY,
                     wait_cnt: 2'h0,
                     pc: RESET_PC,
                     stack_wdata: 8'h00,
                     pop_dest: 5'h00,
                     rf_waddr: 5'h00,
                     rf_wdata: 8'h00,
                     default: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign pc_out = state_reg.pc;
  assign taken_out = state_reg.taken;
  assign stack_wr_out = state_reg.stack_wr;
  assign stack_wdata_out = state_reg.stack_wdata;
  assign stack_rd_out = state_reg.stack_rd;
  assign rf_we_out = state_reg.rf_we;
  assign rf_waddr_out = state_reg.rf_waddr;
  assign rf_wdata_out = state_reg.rf_wdata;
  assign sleep_out = state_reg.sleep;
  assign watchdog_restart_out = state_reg.watchdog_restart;
  assign break_out = state_reg.brk;

endmodule : bsc_decoder

// ### bsc_core_model.sv
// Purpose: Register file, I/O space and stack around the decoder.
// Assumes: Read data answer in the cycle of the address.
// Notes: The stack grows upward from entry zero.
`timescale 1ns/1ns

module bsc_core_model (
  // Clock
  input wire logic clk_in,
  // Lookups
  input wire logic [4:0] reg_addr_in,
  input wire logic [4:0] io_addr_in,
  output logic [7:0] reg_data_out,
  output logic [7:0] io_data_out,
  // Stack and write back
  input wire logic stack_wr_in,
  input wire logic stack_rd_in,
  input wire logic [7:0] stack_wdata_in,
  output logic [7:0] stack_rdata_out,
  input wire logic rf_we_in,
  input wire logic [4:0] rf_waddr_in,
  input wire logic [7:0] rf_wdata_in
);
  logic [7:0] regs [32];
  logic [7:0] io [32];
  logic [7:0] mem [64];
  logic [5:0] sp = 6'h00;
  logic [7:0] noise = 8'h5A;

  assign reg_data_out = regs[reg_addr_in];
  assign io_data_out = io[io_addr_in];
  // Outside a read the lines churn, so a late sample cannot match by luck.
  assign stack_rdata_out = stack_rd_in ? mem[sp - 6'h01] : noise;

  always @(posedge clk_in) begin
    noise <= noise + 8'h3B;
    if (stack_wr_in) begin
      mem[sp] <= stack_wdata_in;
      sp <= sp + 6'h01;
    end
    if (stack_rd_in) begin
      sp <= sp - 6'h01;
    end
    if (rf_we_in) begin
      regs[rf_waddr_in] <= rf_wdata_in;
    end
  end
endmodule : bsc_core_model

// ### bsc_decoder_sva.sv
// Purpose: Timing and target properties of the decoder.
// Assumes: Reset program counter of zero.
// Notes: Bound to the decoder below.
`timescale 1ns/1ns
`include "bsc_cfg.svh"

module bsc_decoder_sva #(
  parameter int PC_W = 14
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] next_word_in,
  input wire logic ready_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic taken_out,
  input wire logic [7:0] reg_data_in,
  input wire logic [7:0] io_data_in,
  input wire logic [7:0] status_register_in,
  input wire logic stack_wr_out,
  input wire logic [7:0] stack_wdata_out,
  input wire logic [7:0] stack_rdata_in,
  input wire logic stack_rd_out,
  input wire logic rf_we_out,
  input wire logic [4:0] rf_waddr_out,
  input wire logic [7:0] rf_wdata_out,
  input wire logic sleep_out,
  input wire logic watchdog_restart_out,
  input wire logic break_out
);
  logic acc, is_skip, hit, two_w, flag_v, br_set, br_clr;
  logic [PC_W-1:0] pc_p1, pc_p2, pc_p3, br_tgt;

  assign acc = instr_valid_in && ready_out;
  assign flag_v = (instr_in[2:0] == 3'h4) ? status_register_in[2] ^ status_register_in[3]
                                         : status_register_in[instr_in[2:0]];
  assign is_skip = ((instr_in & `BSC_SKIP_REG_MASK) | 16'h0200) == `BSC_SKIP_REG_SET_VAL
                   || ((instr_in & `BSC_SKIP_IO_MASK) | 16'h0200) == `BSC_SKIP_IO_SET_VAL;
  // Bit 9 tells set from clear and bit 13 register from I/O in both skip families.
  assign hit = is_skip && (instr_in[9] == (instr_in[13] ? reg_data_in[instr_in[2:0]] : io_data_in[instr_in[2:0]]));
  assign two_w = (next_word_in & 16'hFC0F) == 16'h9000 || (next_word_in & 16'hFE0C) == 16'h940C;
  assign br_set = (instr_in & `BSC_BRANCH_MASK) == `BSC_BRANCH_SET_VAL;
  assign br_clr = (instr_in & `BSC_BRANCH_MASK) == `BSC_BRANCH_CLR_VAL;
  assign pc_p1 = pc_out + 1'b1;
  assign pc_p2 = pc_out + 2'h2;
  assign pc_p3 = pc_out + 2'h3;
  assign br_tgt = pc_p1 + {{(PC_W-7){instr_in[9]}}, instr_in[9:3]};

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_one_stall;
    !ready_out ##1 ready_out;
  endsequence
  sequence s_two_stall;
    !ready_out ##1 s_one_stall;
  endsequence

  a_reset_home: assert property (disable iff (1'b0) rst_in |=> pc_out == '0 && ready_out && !taken_out)
    else $error("reset state wrong");
  a_skip_pass: assert property (acc && is_skip && !hit |=> pc_out == $past(pc_p1) && ready_out && !taken_out)
    else $error("untaken skip wrong");
  a_skip_one: assert property (acc && hit && !two_w |=> pc_out == $past(pc_p2) && taken_out ##0 s_one_stall)
    else $error("one word skip wrong");
  a_skip_two: assert property (acc && hit && two_w |=> pc_out == $past(pc_p3) && taken_out ##0 s_two_stall)
    else $error("two word skip wrong");
  a_branch_go: assert property (acc && (br_set && flag_v || br_clr && !flag_v)
    |=> pc_out == $past(br_tgt) && taken_out ##0 s_one_stall) else $error("taken branch wrong");
  a_branch_stay: assert property (acc && (br_set && !flag_v || br_clr && flag_v)
    |=> pc_out == $past(pc_p1) && ready_out && !taken_out) else $error("untaken branch wrong");
  a_push_store: assert property (acc && (instr_in & `BSC_STACK_MASK) == `BSC_PUSH_VAL
    |=> stack_wr_out && stack_wdata_out == $past(reg_data_in) ##0 s_one_stall) else $error("push wrong");
  a_pop_load: assert property (acc && (instr_in & `BSC_STACK_MASK) == `BSC_POP_VAL
    |=> stack_rd_out && !ready_out ##1 rf_we_out && rf_waddr_out == $past(instr_in[8:4], 2)
    && rf_wdata_out == $past(stack_rdata_in)) else $error("pop wrong");
  a_sleep_pulse: assert property (acc && instr_in == `BSC_SLEEP_VAL
    |=> sleep_out && ready_out && pc_out == $past(pc_p1)) else $error("sleep wrong");
  a_restart_pulse: assert property (acc && instr_in == `BSC_WATCHDOG_RESTART_VAL
    |=> watchdog_restart_out && ready_out) else $error("watchdog restart wrong");
  a_break_pulse: assert property (acc && instr_in == `BSC_BREAK_VAL |=> break_out && ready_out)
    else $error("break wrong");
endmodule : bsc_decoder_sva

bind bsc_decoder bsc_decoder_sva #(.PC_W(PC_W)) i_sva (
  .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
  .next_word_in(next_word_in), .ready_out(ready_out), .pc_out(pc_out), .taken_out(taken_out),
  .reg_data_in(reg_data_in), .io_data_in(io_data_in), .status_register_in(status_register_in),
  .stack_wr_out(stack_wr_out), .stack_wdata_out(stack_wdata_out), .stack_rdata_in(stack_rdata_in),
  .stack_rd_out(stack_rd_out), .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out),
  .rf_wdata_out(rf_wdata_out), .sleep_out(sleep_out), .watchdog_restart_out(watchdog_restart_out),
  .break_out(break_out));

// ### testbench.sv
// Purpose: Random instruction run against a bench model of the decoder.
// Assumes: Partner model answers lookups in the same cycle.
// Notes: One instruction in flight at a time.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module testbench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic instr_valid_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [15:0] next_word_in = 16'h0000;
  logic [7:0] status_register_in = 8'h00;
  logic ready_out, taken_out, stack_wr_out, stack_rd_out, rf_we_out, sleep_out, watchdog_restart_out, break_out;
  logic [13:0] pc_out;
  logic [13:0] exp_pc = 14'h0000;
  logic [4:0] reg_addr_out, io_addr_out, rf_waddr_out;
  logic [7:0] reg_data_in, io_data_in, stack_wdata_out, stack_rdata_in, rf_wdata_out;
  logic [7:0] stk_q [$];
  logic [15:0] nws [6] = '{16'h940C, 16'h940E, 16'h9010, 16'h9200, 16'h0000, 16'h95A8};
  logic [15:0] ctl_w [4] = '{16'h9588, 16'h95A8, 16'h9598, 16'h0000};
  logic [4:0] ctl_p [4] = '{5'h04, 5'h02, 5'h01, 5'h00};
  int errors = 0;
  int compares = 0;
  int cyc_count = 0;

  always #4 clk_in = ~clk_in;

  bsc_decoder i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .next_word_in(next_word_in), .ready_out(ready_out), .pc_out(pc_out), .taken_out(taken_out),
    .reg_addr_out(reg_addr_out), .reg_data_in(reg_data_in), .io_addr_out(io_addr_out),
    .io_data_in(io_data_in), .status_register_in(status_register_in), .stack_wr_out(stack_wr_out),
    .stack_wdata_out(stack_wdata_out), .stack_rd_out(stack_rd_out), .stack_rdata_in(stack_rdata_in),
    .rf_we_out(rf_we_out), .rf_waddr_out(rf_waddr_out), .rf_wdata_out(rf_wdata_out),
    .sleep_out(sleep_out), .watchdog_restart_out(watchdog_restart_out), .break_out(break_out));

  bsc_core_model i_mem (
    .clk_in(clk_in), .reg_addr_in(reg_addr_out), .io_addr_in(io_addr_out), .reg_data_out(reg_data_in),
    .io_data_out(io_data_in), .stack_wr_in(stack_wr_out), .stack_rd_in(stack_rd_out),
    .stack_wdata_in(stack_wdata_out), .stack_rdata_out(stack_rdata_in), .rf_we_in(rf_we_out),
    .rf_waddr_in(rf_waddr_out), .rf_wdata_in(rf_wdata_out));

  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Offer one instruction, then follow it until the decoder is ready again.
  task automatic run(input logic [15:0] w, input logic [15:0] nw, input logic [7:0] sr, input int dpc,
                     input int cyc, input logic tk, input logic [4:0] pl, input logic [7:0] ed);
    int n;
    n = 1;
    @(posedge clk_in);
    instr_in <= w;
    next_word_in <= nw;
    status_register_in <= sr;
    instr_valid_in <= 1'b1;
    exp_pc = exp_pc + 14'(dpc);
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    #1;
    `CHK("pc", exp_pc, pc_out)
    `CHK("taken", tk, taken_out)
    `CHK("pulses", pl, {stack_wr_out, stack_rd_out, sleep_out, watchdog_restart_out, break_out})
    if (pl[4]) `CHK("push data", ed, stack_wdata_out)
    while (ready_out !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("cycles", cyc, n)
    if (pl[3]) `CHK("pop", {1'b1, w[8:4], ed}, {rf_we_out, rf_waddr_out, rf_wdata_out})
    // The write back lands at the next edge; the bench must not read the register file before it.
    if (pl[3]) begin
      @(posedge clk_in);
      #1;
    end
  endtask : run

  always @(posedge clk_in) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    int kind, r, b, s, soff, idx, two;
    logic [15:0] w;
    logic [7:0] sr, ed;
    logic hit;
    void'($urandom(90));
    for (int i = 0; i < 32; i++) begin
      i_mem.regs[i] = 8'($urandom);
      i_mem.io[i] = 8'($urandom);
    end
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      kind = $urandom_range(0, 8);
      r = $urandom_range(0, 31);
      b = $urandom_range(0, 7);
      s = $urandom_range(0, 7);
      soff = $urandom_range(0, 127);
      idx = $urandom_range(0, 5);
      two = (idx < 4) ? 1 : 0;
      sr = 8'($urandom);
      case (kind)
        0: begin w = 16'hFC00; hit = !i_mem.regs[r][b]; end
        1: begin w = 16'hFE00; hit = i_mem.regs[r][b]; end
        2: begin w = 16'h9900; hit = !i_mem.io[r][b]; end
        3: begin w = 16'h9B00; hit = i_mem.io[r][b]; end
        default: begin w = 16'h0000; hit = ((s == 4) ? sr[2] ^ sr[3] : sr[s]) ^ (kind == 5); end
      endcase
      if (kind < 4) begin
        w = w | 16'(b) | ((kind < 2) ? 16'(r << 4) : 16'(r << 3));
        run(w, nws[idx], sr, hit ? 2 + two : 1, hit ? 2 + two : 1, hit, 5'h00, 8'h00);
      end else if (kind < 6) begin
        w = ((kind == 4) ? 16'hF000 : 16'hF400) | 16'(soff << 3) | 16'(s);
        soff = (soff > 63) ? soff - 128 : soff;
        run(w, nws[idx], sr, hit ? soff + 1 : 1, hit ? 2 : 1, hit, 5'h00, 8'h00);
      end else if (kind == 6 || stk_q.size() == 0) begin
        ed = i_mem.regs[r];
        stk_q.push_back(ed);
        run(16'h920F | 16'(r << 4), nws[idx], sr, 1, 2, 1'b0, 5'h10, ed);
      end else if (kind == 7) begin
        ed = stk_q.pop_back();
        run(16'h900F | 16'(r << 4), nws[idx], sr, 1, 2, 1'b0, 5'h08, ed);
      end else begin
        run(ctl_w[b % 4], nws[idx], sr, 1, 1, 1'b0, ctl_p[b % 4], 8'h00);
      end
    end
    give_verdict();
  end
endmodule : testbench
